// >>> design/nvs_pkg.sv
// Shared constants and types for the nonvolatile store/recall host controller.
package nvs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 20;
	localparam int ACCESS_NS = 45;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_LAT = 3;
	localparam int STROBE_CYC = ACCESS_CYC + SYNC_LAT;
	localparam int STORE_US = 10000;
	localparam int STORE_CYC = STORE_US * 1000 / CLK_NS;
	localparam int RECALL_US = 20;
	localparam int RECALL_CYC = RECALL_US * 1000 / CLK_NS;
	localparam int LINE_LOW_NS = 200;
	localparam int LINE_LOW_CYC = (LINE_LOW_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------
	// Trigger addresses
	// ----------------------------------------
	localparam logic [12:0] TRIG_ADDR0 = 13'h0000;
	localparam logic [12:0] TRIG_ADDR1 = 13'h1555;
	localparam logic [12:0] TRIG_ADDR2 = 13'h0AAA;
	localparam logic [12:0] TRIG_ADDR3 = 13'h1FFF;
	localparam logic [12:0] TRIG_ADDR4 = 13'h10F0;
	localparam logic [12:0] TRIG_ADDR5 = 13'h0F0F;
	localparam logic [2:0] TRIG_LAST = 3'h5;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_SW_STORE, OP_SW_RECALL, OP_HW_STORE} nvs_op_t;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_HW_PULL, ST_WAIT_XFER,
		ST_WAIT_LINE} nvs_state_t;

	typedef struct packed {
		nvs_op_t op;
		logic [12:0] addr;
		logic [7:0] data;
	} nvs_cmd_t;

	typedef struct packed {
		logic [12:0] addr;
		logic [7:0] dqOut;
		logic dqOe;
		logic chipEnN;
		logic outEnN;
		logic writeEnN;
		logic lineOut;
		logic lineOe;
	} nvs_pins_t;

	typedef struct packed {
		nvs_state_t st;
		nvs_op_t op;
		logic [2:0] step;
		logic [23:0] cnt;
		nvs_pins_t pins;
		logic cmdReady;
		logic rspValid;
		logic [7:0] rspData;
	} nvs_regs_t;

	// Address of a given step of the trigger sequence.
	function automatic logic [12:0] trigAddr(input logic [2:0] step);
		case (step)
			3'h0: trigAddr = TRIG_ADDR0;
			3'h1: trigAddr = TRIG_ADDR1;
			3'h2: trigAddr = TRIG_ADDR2;
			3'h3: trigAddr = TRIG_ADDR3;
			3'h4: trigAddr = TRIG_ADDR4;
			default: trigAddr = TRIG_ADDR5;
		endcase
	endfunction

endpackage

// >>> design/nvs_sync.sv
// Three-stage input synchroniser that passes a change once stages two and three agree.
`timescale 1ns/1ps
module nvs_sync
	#(parameter int WIDTH = 1)
	(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
	);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	// Stage one feeds only stage two; the output follows once two and three agree.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
			dout <= '1;
		end
		else
		begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
			begin
				dout <= s3;
			end
		end
	end

endmodule

// >>> design/nvs_host.sv
// Host controller that drives an 8K x 8 nonvolatile SRAM and starts its stores and recalls.
`timescale 1ns/1ps
module nvs_host
	import nvs_pkg::*;
	#(
	parameter int STORE_WAIT = STORE_CYC,
	parameter int RECALL_WAIT = RECALL_CYC
	)
	(
	input wire logic clock,
	input wire logic rstn,
	input wire logic cmdValid,
	input wire nvs_cmd_t cmd,
	output logic cmdReady,
	output logic rspValid,
	output logic [7:0] rspData,
	output logic xferBusy,
	output logic [12:0] memAddr,
	output logic [7:0] memDqOut,
	output logic memDqOe,
	input wire logic [7:0] memDqIn,
	output logic memChipEnN,
	output logic memOutEnN,
	output logic memWriteEnN,
	output logic storeBusyLineOut,
	output logic storeBusyLineOe,
	input wire logic storeBusyLineIn
	);

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	logic [8:0] syncOut;
	logic lineHigh;
	logic [7:0] dqSync;

	nvs_sync #(.WIDTH(9)) uSync (
		.clock(clock),
		.rstn(rstn),
		.din({memDqIn, storeBusyLineIn}),
		.dout(syncOut)
	);

	// Synchronised data bus and store/busy line level.
	assign lineHigh = syncOut[0];
	assign dqSync = syncOut[8:1];

	// ----------------------------------------
	// State
	// ----------------------------------------
	nvs_regs_t r;
	nvs_regs_t next_r;
	logic isSeq;

	// Trigger sequences run as back-to-back reads with no foreign access between.
	assign isSeq = (r.op == OP_SW_STORE) || (r.op == OP_SW_RECALL);

	// Next-state logic for the whole controller.
	always_comb
	begin
		next_r = r;
		next_r.rspValid = 1'b0;
		next_r.pins.lineOut = 1'b0;
		case (r.st)
			ST_IDLE:
			begin
				// No access starts while any device on the shared line is storing.
				next_r.cmdReady = lineHigh;
				if (cmdValid && r.cmdReady)
				begin
					next_r.cmdReady = 1'b0;
					next_r.op = cmd.op;
					next_r.step = 3'h0;
					case (cmd.op)
						OP_READ, OP_WRITE:
						begin
							next_r.pins.addr = cmd.addr;
							next_r.pins.dqOut = cmd.data;
							next_r.pins.dqOe = (cmd.op == OP_WRITE);
							next_r.st = ST_SETUP;
						end
						OP_SW_STORE, OP_SW_RECALL:
						begin
							next_r.pins.addr = trigAddr(3'h0);
							next_r.st = ST_SETUP;
						end
						OP_HW_STORE:
						begin
							next_r.pins.lineOe = 1'b1;
							next_r.cnt = 24'(LINE_LOW_CYC);
							next_r.st = ST_HW_PULL;
						end
						default:
						begin
							next_r.st = ST_IDLE;
						end
					endcase
				end
			end
			ST_SETUP:
			begin
				// Address is stable; open the chip-enable strobe.
				next_r.pins.chipEnN = 1'b0;
				next_r.pins.writeEnN = (r.op != OP_WRITE);
				next_r.pins.outEnN = (r.op != OP_READ);
				next_r.cnt = 24'(STROBE_CYC);
				next_r.st = ST_STROBE;
			end
			ST_STROBE:
			begin
				next_r.cnt = r.cnt - 24'h000001;
				if (r.cnt == 24'h000001)
				begin
					next_r.pins.chipEnN = 1'b1;
					next_r.pins.writeEnN = 1'b1;
					next_r.pins.outEnN = 1'b1;
					next_r.rspValid = (r.op == OP_READ);
					next_r.rspData = dqSync;
					next_r.st = ST_GAP;
				end
			end
			ST_GAP:
			begin
				// Data is held one cycle past the strobe for write hold time.
				next_r.pins.dqOe = 1'b0;
				if (isSeq && (r.step == TRIG_LAST))
				begin
					// Sixth read issued; the transfer now runs inside the device.
					next_r.cnt = (r.op == OP_SW_RECALL) ? 24'(RECALL_WAIT) : 24'(STORE_WAIT);
					next_r.st = ST_WAIT_XFER;
				end
				else if (isSeq)
				begin
					next_r.step = r.step + 3'h1;
					next_r.pins.addr = trigAddr(r.step + 3'h1);
					next_r.st = ST_SETUP;
				end
				else
				begin
					next_r.st = ST_IDLE;
				end
			end
			ST_HW_PULL:
			begin
				next_r.cnt = r.cnt - 24'h000001;
				if (r.cnt == 24'h000001)
				begin
					// Release after the minimum width; the device keeps the line low.
					next_r.pins.lineOe = 1'b0;
					next_r.cnt = 24'(STORE_WAIT);
					next_r.st = ST_WAIT_XFER;
				end
			end
			ST_WAIT_XFER:
			begin
				// Chip stays deselected for the whole transfer.
				next_r.cnt = r.cnt - 24'h000001;
				if (r.cnt == 24'h000001)
				begin
					next_r.st = ST_WAIT_LINE;
				end
			end
			ST_WAIT_LINE:
			begin
				if (lineHigh)
				begin
					next_r.st = ST_IDLE;
				end
			end
			default:
			begin
				next_r.st = ST_IDLE;
			end
		endcase
	end

	// Register the whole state.
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			r.st <= ST_IDLE;
			r.op <= OP_READ;
			r.step <= 3'h0;
			r.cnt <= 24'h000000;
			r.pins.addr <= 13'h0000;
			r.pins.dqOut <= 8'h00;
			r.pins.dqOe <= 1'b0;
			r.pins.chipEnN <= 1'b1;
			r.pins.outEnN <= 1'b1;
			r.pins.writeEnN <= 1'b1;
			r.pins.lineOut <= 1'b0;
			r.pins.lineOe <= 1'b0;
			r.cmdReady <= 1'b0;
			r.rspValid <= 1'b0;
			r.rspData <= 8'h00;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign cmdReady = r.cmdReady;
	assign rspValid = r.rspValid;
	assign rspData = r.rspData;
	assign memAddr = r.pins.addr;
	assign memDqOut = r.pins.dqOut;
	assign memDqOe = r.pins.dqOe;
	assign memChipEnN = r.pins.chipEnN;
	assign memOutEnN = r.pins.outEnN;
	assign memWriteEnN = r.pins.writeEnN;
	assign storeBusyLineOut = r.pins.lineOut;
	assign storeBusyLineOe = r.pins.lineOe;

	// Busy flag is its own flop, loaded from a decode of the next state.
	logic busyFlop;
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			busyFlop <= 1'b0;
		end
		else
		begin
			busyFlop <= (next_r.st == ST_WAIT_XFER) || (next_r.st == ST_WAIT_LINE)
				|| (next_r.st == ST_HW_PULL);
		end
	end
	assign xferBusy = busyFlop;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_first_trigger: assert property (@(posedge clock) disable iff (!rstn)
		(r.st == ST_STROBE && isSeq && r.step == 3'h0) |-> r.pins.addr == 13'h0000)
		else $error("First trigger read not at address zero.");

	a_second_trigger: assert property (@(posedge clock) disable iff (!rstn)
		(r.st == ST_STROBE && isSeq && r.step == 3'h1) |-> r.pins.addr == 13'h1555)
		else $error("Second trigger read at wrong address.");

	a_sixth_trigger: assert property (@(posedge clock) disable iff (!rstn)
		(r.st == ST_STROBE && isSeq && r.step == 3'h5) |-> r.pins.addr == 13'h0F0F)
		else $error("Sixth trigger read at wrong address.");

	a_trigger_read_only: assert property (@(posedge clock) disable iff (!rstn)
		(isSeq && !r.pins.chipEnN) |-> (r.pins.writeEnN && !r.pins.dqOe))
		else $error("Trigger access is not a read.");

	a_recall_wait: assert property (@(posedge clock) disable iff (!rstn)
		(r.st == ST_GAP && r.op == OP_SW_RECALL && r.step == 3'h5)
		|=> (r.st == ST_WAIT_XFER && r.cnt == 24'(RECALL_WAIT)))
		else $error("Recall wait not loaded after sixth read.");

	a_seq_no_gap: assert property (@(posedge clock) disable iff (!rstn)
		(r.st == ST_GAP && isSeq && r.step != 3'h5) |=> (r.st == ST_SETUP ##1 !r.pins.chipEnN))
		else $error("Trigger reads not back to back.");

	a_line_pull_width: assert property (@(posedge clock) disable iff (!rstn)
		$rose(r.pins.lineOe) |-> r.pins.lineOe [*8])
		else $error("Store/busy line released too early.");

	a_xfer_deselect: assert property (@(posedge clock) disable iff (!rstn)
		(r.st == ST_WAIT_XFER || r.st == ST_WAIT_LINE) |-> (r.pins.chipEnN && !r.pins.dqOe))
		else $error("Chip selected during a transfer.");

	a_line_low_only: assert property (@(posedge clock) disable iff (!rstn)
		!r.pins.lineOut)
		else $error("Store/busy line driven high.");

	a_wait_line_high: assert property (@(posedge clock) disable iff (!rstn)
		(r.st == ST_WAIT_LINE && !lineHigh) |=> r.st == ST_WAIT_LINE)
		else $error("Left line wait while line still low.");

endmodule

// >>> sim/nvs_dev_model.sv
// Behavioural model of the 8K x 8 nonvolatile memory driven by the host controller.
`timescale 1ns/1ps
module nvs_dev_model
	import nvs_pkg::*;
	#(
	parameter int STORE_NS = 1500,
	parameter int LOW_MIN_NS = 100,
	parameter int GRACE_NS = 40,
	parameter bit CAP_CHARGED = 1'b1
	)
	(
	input wire logic [12:0] addr,
	input wire logic [7:0] dqIn,
	output logic [7:0] dqOut,
	input wire logic chipEnN,
	input wire logic outEnN,
	input wire logic writeEnN,
	input wire logic lineLevel,
	output logic lineLow
	);
	logic [12:0] seqAddr [6] = '{TRIG_ADDR0, TRIG_ADDR1, TRIG_ADDR2, TRIG_ADDR3, TRIG_ADDR4,
		TRIG_ADDR5};
	logic [7:0] sram [8192];
	logic [2:0] step = 3'h0;
	logic busy = 1'b0;
	logic written = 1'b0;
	logic [7:0] lastOut = 8'h00;
	logic [12:0] gAddr;
	logic [2:0] gCtl;
	initial lineLow = 1'b0;

	// Drives read data; a floating bus shows the inverse of the last byte.
	always @*
	begin
		if (!chipEnN && !outEnN && writeEnN && !busy && lineLevel)
		begin
			dqOut = sram[addr];
			lastOut = dqOut;
		end
		else
			dqOut = ~lastOut;
	end

	// Holds the line low for the whole store, then stays off until it is high.
	task automatic runStore;
		busy = 1'b1;
		lineLow = 1'b1;
		#(STORE_NS);
		lineLow = 1'b0;
		written = 1'b0;
		wait (lineLevel);
		busy = 1'b0;
	endtask

	// Takes each access at the chip-enable fall and tracks the trigger sequence.
	always @(negedge chipEnN)
	begin
		#1;
		if (busy || !lineLevel)
			step = 3'h0;
		else if (!writeEnN)
		begin
			sram[addr] = dqIn;
			written = 1'b1;
			step = 3'h0;
		end
		else if (addr === seqAddr[step])
		begin
			step = (step == 3'h5) ? 3'h0 : step + 3'h1;
			if (step == 3'h0 && CAP_CHARGED)
				runStore();
		end
		else
			step = (addr === seqAddr[0]) ? 3'h1 : 3'h0;
	end

	// An outside low past the minimum width starts a store after the grace window if the array was written.
	always @(negedge lineLevel)
	begin
		if (!lineLow && !busy)
		begin
			#(LOW_MIN_NS);
			if (!lineLevel)
			begin
				// Array works through the grace window; any address or control pin change cuts it short.
				gAddr = addr;
				gCtl = {chipEnN, outEnN, writeEnN};
				for (int t = 0; t < GRACE_NS && addr === gAddr
					&& {chipEnN, outEnN, writeEnN} === gCtl; t++)
					#1;
				if (written && CAP_CHARGED)
					runStore();
				else
				begin
					busy = 1'b1;
					wait (lineLevel);
					busy = 1'b0;
				end
			end
		end
	end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the host controller against the memory model.
`timescale 1ns/1ps
module tb_top;
	import nvs_pkg::*;
	// Shortened transfer waits so the run stays brief.
	localparam int SIM_STORE = 50;
	localparam int SIM_RECALL = 20;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic cmdValid = 1'b0;
	nvs_cmd_t cmd = '0;
	logic cmdReady, rspValid, xferBusy, memDqOe, memChipEnN, memOutEnN, memWriteEnN;
	logic lineOut, lineOe, devLow, line, sawLow;
	logic [7:0] rspData, memDqOut, devDq;
	logic [12:0] memAddr;
	logic [7:0] expData [$];
	logic [12:0] expAddr [$];
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	int oeCnt = 0;
	int busyCnt = 0;
	logic [12:0] a [8];
	logic [7:0] d [8];

	// Open-drain line with a pull-up.
	assign line = !(lineOe && !lineOut) && !devLow;

	nvs_host #(.STORE_WAIT(SIM_STORE), .RECALL_WAIT(SIM_RECALL)) dut (.clock(clock), .rstn(rstn),
		.cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady), .rspValid(rspValid),
		.rspData(rspData), .xferBusy(xferBusy), .memAddr(memAddr), .memDqOut(memDqOut),
		.memDqOe(memDqOe), .memDqIn(devDq), .memChipEnN(memChipEnN), .memOutEnN(memOutEnN),
		.memWriteEnN(memWriteEnN), .storeBusyLineOut(lineOut), .storeBusyLineOe(lineOe),
		.storeBusyLineIn(line));

	nvs_dev_model dev (.addr(memAddr), .dqIn(memDqOe ? memDqOut : ~memDqOut), .dqOut(devDq),
		.chipEnN(memChipEnN), .outEnN(memOutEnN), .writeEnN(memWriteEnN), .lineLevel(line),
		.lineLow(devLow));

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Compares each read response and watches line, busy and ready at every falling edge.
	always @(negedge clock)
	begin
		cycles++;
		if (!line)
			sawLow = 1'b1;
		if (lineOe === 1'b1)
			oeCnt++;
		if (xferBusy === 1'b1)
			busyCnt++;
		if (xferBusy === 1'b1)
			check("xferChipEnN", memChipEnN, 1);
		if (rspValid === 1'b1)
			check("rspData", rspData, expData.pop_front());
		if (lineOe === 1'b1)
			check("lineOut", lineOut, 0);
		if (!line)
			check("cmdReady", cmdReady, 0);
		if (cycles == 20000)
		begin
			miscompares++;
			report_and_stop();
		end
	end

	// Checks each trigger strobe against the expected address order.
	always @(negedge memChipEnN)
	begin
		if (expAddr.size() > 0)
		begin
			check("seqAddr", memAddr, expAddr.pop_front());
			check("writeEnN", memWriteEnN, 1);
		end
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task automatic doCmd(input nvs_op_t op, input logic [12:0] ad, input logic [7:0] dt);
		int n;
		n = 0;
		cmdValid = 1'b1;
		cmd = '{op: op, addr: ad, data: dt};
		while (cmdReady !== 1'b1 && n < 3000)
		begin
			@(negedge clock);
			n++;
		end
		@(negedge clock);
		cmdValid = 1'b0;
		n = 0;
		while (cmdReady !== 1'b1 && n < 3000)
		begin
			@(negedge clock);
			n++;
		end
		check("cmdTimeout", n < 3000, 1);
	endtask

	// Runs one trigger sequence; the busy time must cover the whole transfer wait.
	task automatic seqCmd(input nvs_op_t op, input int wt);
		expAddr = '{TRIG_ADDR0, TRIG_ADDR1, TRIG_ADDR2, TRIG_ADDR3, TRIG_ADDR4, TRIG_ADDR5};
		sawLow = 1'b0;
		busyCnt = 0;
		doCmd(op, 13'h0000, 8'h00);
		check("seqLeft", expAddr.size(), 0);
		check("sawLow", sawLow, 1);
		check("busyLong", busyCnt > wt, 1);
		check("xferBusy", xferBusy, 0);
	endtask

	initial
	begin
		forever #10 clock = ~clock;
	end

	initial
	begin
		void'($urandom(70629));
		repeat (12) @(negedge clock);
		rstn = 1'b1;
		repeat (2) @(negedge clock);
		for (int i = 0; i < 8; i++)
		begin
			a[i] = {3'(i), 10'($urandom())}; // Distinct upper bits avoid overwrites.
			d[i] = 8'($urandom());
			doCmd(OP_WRITE, a[i], d[i]);
			expData.push_back(d[i]);
			doCmd(OP_READ, a[i], 8'h00);
		end
		seqCmd(OP_SW_STORE, SIM_STORE);
		oeCnt = 0;
		sawLow = 1'b0;
		busyCnt = 0;
		doCmd(OP_WRITE, a[0], d[0]);
		doCmd(OP_HW_STORE, 13'h0000, 8'h00);
		check("oeCnt", oeCnt, LINE_LOW_CYC);
		check("sawLow", sawLow, 1);
		check("busyHw", busyCnt > LINE_LOW_CYC + SIM_STORE, 1);
		seqCmd(OP_SW_RECALL, SIM_RECALL);
		for (int i = 0; i < 8; i++)
		begin
			expData.push_back(d[i]);
			doCmd(OP_READ, a[i], 8'h00);
		end
		repeat (4) @(negedge clock);
		check("rspLeft", expData.size(), 0);
		report_and_stop();
	end
endmodule
